// >>> hw/rjb_pkg.sv
// Constants and types for the per-port receive jabber monitor.
// Assumes a single 20 MHz system clock and synchronous port inputs.
//
// Behaviour
// R01: Each port cuts off overlong receptions itself
// R02: Enter jabber after reception exceeds timer period
// R03: Jabber blocks receive activity toward repeater core
// R04: Jabber blocks core output to port transmitter
// R05: Leave jabber on reset or carrier loss
// R06: Receive timer measures continuous reception duration
// R07: Timer period parameterised, restarts each carrier event
package rjb_pkg;

  // =========================================================
  // Timing
  // =========================================================
  localparam int unsigned RJB_CLK_HZ       = 20_000_000;
  localparam int unsigned RJB_CNT_W        = 24;
  // Default excessive-reception period in microseconds
  localparam int unsigned RJB_JABBER_US    = 500;
  localparam int unsigned RJB_JABBER_CYC   =
    (RJB_JABBER_US * (RJB_CLK_HZ / 1_000_000));
  localparam logic [RJB_CNT_W-1:0] RJB_CNT_ZERO = 24'h000000;
  localparam logic [RJB_CNT_W-1:0] RJB_CNT_ONE  = 24'h000001;

  // =========================================================
  // States
  // =========================================================
  typedef enum logic [1:0] {
    RJB_IDLE,
    RJB_RECV,
    RJB_JABBER
  } rjb_state_t;

endpackage : rjb_pkg

// >>> hw/rjb_port.sv
// Receive jabber monitor for one repeater port: times each carrier
// event and cuts the port off from the repeater core when it runs long.
// Assumes carrier, receive activity and core output are synchronous to
// clk_sys_i, and that the core ignores this port while jabber_o is high.
`timescale 1ns/10ps
module rjb_port
  import rjb_pkg::*;
#(
  parameter logic [RJB_CNT_W-1:0] JABBER_CYC = RJB_CNT_W'(RJB_JABBER_CYC)
) (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic carrier_i,   // Port carrier indication
  input  wire logic rx_act_i,    // Receive activity from port
  input  wire logic core_tx_i,   // Core output toward port
  output logic      core_rx_o,   // Activity passed to core
  output logic      port_tx_o,   // Output passed to transmitter
  output logic      jabber_o     // Port is in jabber state
);

  // =========================================================
  // Reset release
  // =========================================================
  logic rst_s1_q;
  logic rstn_q;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rstn_q   <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rstn_q   <= rst_s1_q;
    end
  end

  // =========================================================
  // Receive timer
  // =========================================================
  rjb_state_t           state_q;
  rjb_state_t           state_d;
  logic [RJB_CNT_W-1:0] cnt_q;
  logic [RJB_CNT_W-1:0] cnt_d;
  wire                  expired;
  wire                  jab_w;

  // Timer exceeded once count reaches the period
  assign expired = (cnt_q >= JABBER_CYC); // R02 R06

  // Jabber state decode, shared by gating and checks
  assign jab_w   = (state_q == RJB_JABBER); // R01

  // Next state and count
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      RJB_IDLE: begin
        cnt_d = RJB_CNT_ZERO; // R07
        if (carrier_i) begin
          state_d = RJB_RECV;
          cnt_d   = RJB_CNT_ONE; // R07
        end
      end
      RJB_RECV: begin
        if (!carrier_i) begin
          state_d = RJB_IDLE;
          cnt_d   = RJB_CNT_ZERO;
        end else if (expired) begin
          state_d = RJB_JABBER; // R01 R02
        end else begin
          cnt_d = cnt_q + RJB_CNT_ONE; // R06 R07
        end
      end
      RJB_JABBER: begin
        if (!carrier_i) begin
          state_d = RJB_IDLE; // R05
          cnt_d   = RJB_CNT_ZERO;
        end
      end
      default: begin
        state_d = RJB_IDLE;
        cnt_d   = RJB_CNT_ZERO;
      end
    endcase
  end

  // State registers, cleared by the synchronised reset
  always_ff @(posedge clk_sys_i or negedge rstn_q) begin
    if (!rstn_q) begin
      state_q <= RJB_IDLE; // R05
      cnt_q   <= RJB_CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // =========================================================
  // Receive timer checks
  // =========================================================
  // Entry once the period has run out
  enter_jab_a: assert property ( // R02
    @(posedge clk_sys_i) disable iff (!rstn_q)
    (state_q == RJB_RECV && carrier_i && expired) |=> jab_w)
    else $error("jabber not entered after timeout");

  // Entry only after the count reached the period
  no_early_a: assert property ( // R06
    @(posedge clk_sys_i) disable iff (!rstn_q)
    $rose(jab_w) |-> $past(cnt_q) >= JABBER_CYC)
    else $error("jabber entered too early");

  // Entry only from a timed reception
  jab_entry_a: assert property ( // R02
    @(posedge clk_sys_i) disable iff (!rstn_q)
    $rose(jab_w) |-> $past(state_q) == RJB_RECV)
    else $error("jabber entered outside a reception");

  // Counter advances by one per carrier cycle until the period is reached
  cnt_step_a: assert property ( // R06
    @(posedge clk_sys_i) disable iff (!rstn_q)
    (state_q == RJB_RECV && carrier_i && !expired)
      |=> cnt_q == $past(cnt_q) + RJB_CNT_ONE)
    else $error("timer did not advance");

  // Counter never runs past the period
  cnt_bound_a: assert property ( // R06
    @(posedge clk_sys_i) disable iff (!rstn_q)
    (state_q != RJB_IDLE) |-> cnt_q <= JABBER_CYC)
    else $error("timer ran past the period");

  // Fresh count at the start of each carrier event
  cnt_restart_a: assert property ( // R07
    @(posedge clk_sys_i) disable iff (!rstn_q)
    (state_q == RJB_IDLE && carrier_i) |=> cnt_q == RJB_CNT_ONE)
    else $error("timer did not restart");

  // Carrier loss returns to idle with a zero count
  cnt_clear_a: assert property ( // R05
    @(posedge clk_sys_i) disable iff (!rstn_q)
    !carrier_i |=> (state_q == RJB_IDLE && cnt_q == RJB_CNT_ZERO))
    else $error("carrier loss did not clear the timer");

  // Carrier loss releases the port
  jab_exit_a: assert property ( // R05
    @(posedge clk_sys_i) disable iff (!rstn_q)
    (jab_w && !carrier_i) |=> !jab_w)
    else $error("jabber not cleared on carrier loss");

  // Jabber holds while carrier stays
  jab_hold_a: assert property ( // R05
    @(posedge clk_sys_i) disable iff (!rstn_q)
    (jab_w && carrier_i) |=> jab_w)
    else $error("jabber left while carrier present");

  // Port kept out of jabber while reset holds
  rst_quiet_a: assert property ( // R05
    @(posedge clk_sys_i)
    !rstn_q |-> !jab_w)
    else $error("jabber set during reset");

  // =========================================================
  // Reference run length for the checks
  // =========================================================
  // Counts carrier cycles on its own, apart from the timer
  logic [RJB_CNT_W-1:0] run_q;
  logic [RJB_CNT_W-1:0] run_d;
  wire                  run_top;

  // Top value reached, hold there rather than wrap
  assign run_top = (run_q == ~RJB_CNT_ZERO);

  // Restart on carrier loss, else count up
  assign run_d = !carrier_i ? RJB_CNT_ZERO :
                 run_top    ? run_q        :
                              run_q + RJB_CNT_ONE;

  // Run length register, cleared with the state
  always_ff @(posedge clk_sys_i or negedge rstn_q) begin
    if (!rstn_q) begin
      run_q <= RJB_CNT_ZERO;
    end else begin
      run_q <= run_d;
    end
  end

  // Jabber follows once the run passes the period
  jab_late_a: assert property ( // R02
    @(posedge clk_sys_i) disable iff (!rstn_q)
    (run_q > JABBER_CYC) |-> jab_w)
    else $error("jabber missing after a long run");

  // Jabber only after the run passed the period
  jab_early_a: assert property ( // R02
    @(posedge clk_sys_i) disable iff (!rstn_q)
    jab_w |-> (run_q > JABBER_CYC))
    else $error("jabber without a long run");

  // =========================================================
  // Gating toward core and transmitter
  // =========================================================
  // Pass a level through unless the port is cut off
  function automatic logic rjb_gate(input logic lvl, input logic cut);
    return lvl & ~cut;
  endfunction : rjb_gate

  // Status and gated levels, same cycle as the state
  assign jabber_o  = jab_w;
  assign core_rx_o = rjb_gate(rx_act_i, jab_w);  // R03
  assign port_tx_o = rjb_gate(core_tx_i, jab_w); // R04

  // =========================================================
  // Gating checks
  // =========================================================
  // Nothing reaches the core during jabber
  rx_block_a: assert property ( // R03
    @(posedge clk_sys_i) disable iff (!rstn_q)
    jab_w |-> !core_rx_o)
    else $error("receive passed during jabber");

  // Nothing reaches the transmitter during jabber
  tx_block_a: assert property ( // R04
    @(posedge clk_sys_i) disable iff (!rstn_q)
    jab_w |-> !port_tx_o)
    else $error("transmit passed during jabber");

  // Both paths pass untouched outside jabber
  pass_free_a: assert property ( // R01
    @(posedge clk_sys_i) disable iff (!rstn_q)
    !jab_w |-> (core_rx_o == rx_act_i && port_tx_o == core_tx_i))
    else $error("gating while not in jabber");

endmodule : rjb_port

// >>> bench/rjb_far.sv
// Far-side model: port receive path and repeater core.
// Assumes the bench requests carrier at a falling edge.
`timescale 1ns/10ps
module rjb_far (
  input  wire logic clk_sys_i,
  input  wire logic on_i,      // Carrier requested
  output logic      carrier_o, // Carrier to the port
  output logic      rx_act_o,  // Activity, only inside carrier
  output logic      core_tx_o  // Core output, always busy
);
  logic tgl_q = 1'b0;
  // Toggling pattern so a stuck output shows
  always @(negedge clk_sys_i) tgl_q <= ~tgl_q;
  assign carrier_o = on_i;
  assign rx_act_o  = on_i & tgl_q;
  assign core_tx_o = tgl_q;
endmodule : rjb_far

// >>> bench/tb.sv
// Bench for the receive jabber monitor, timer cut to 16 cycles.
// Assumes the far-side model drives carrier, receive activity and core output.
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %b got %b", n, e, s); end end
module tb;
  logic clk_sys_i  = 1'b0;
  logic rstn_i     = 1'b0;
  logic on         = 1'b0;
  logic carrier, rx_act, core_tx, core_rx, port_tx, jabber;
  int   error_cnt  = 0;
  int   num_checks = 0;
  int   cycles     = 0;
  // ==========================================
  // Clock, watchdog, partner and design
  always #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles = cycles + 1;
    if (cycles == 400) begin
      error_cnt++;
      close_out();
    end
  end
  rjb_far i_far (.clk_sys_i, .on_i(on), .carrier_o(carrier),
                 .rx_act_o(rx_act), .core_tx_o(core_tx));
  rjb_port #(.JABBER_CYC(24'h000010)) i_dut (.clk_sys_i, .rstn_i,
    .carrier_i(carrier), .rx_act_i(rx_act), .core_tx_i(core_tx),
    .core_rx_o(core_rx), .port_tx_o(port_tx), .jabber_o(jabber));
  // ==========================================
  // One cycle of carrier c, expecting jabber j
  task automatic cyc(input logic c, input logic j);
    @(negedge clk_sys_i) on = c;
    @(posedge clk_sys_i) #1;
    `CHK("jabber", j, jabber)
    `CHK("core_rx", rx_act & ~j, core_rx)
    `CHK("port_tx", core_tx & ~j, port_tx)
  endtask : cyc
  task automatic t_short;
    for (int k = 1; k <= 16; k++) cyc(1'b1, 1'b0);
    cyc(1'b0, 1'b0);
    $display("short burst done");
  endtask : t_short
  task automatic t_long;
    for (int k = 1; k <= 20; k++) cyc(1'b1, k >= 17);
    cyc(1'b0, 1'b0);
    $display("long burst done");
  endtask : t_long
  task automatic t_restart;
    for (int k = 1; k <= 12; k++) cyc(1'b1, 1'b0);
    cyc(1'b0, 1'b0);
    for (int k = 1; k <= 12; k++) cyc(1'b1, 1'b0);
    cyc(1'b0, 1'b0);
    $display("restart done");
  endtask : t_restart
  task automatic t_reset;
    for (int k = 1; k <= 18; k++) cyc(1'b1, k >= 17);
    @(negedge clk_sys_i) rstn_i = 1'b0;
    #1 `CHK("jabber", 1'b0, jabber)
    @(posedge clk_sys_i) #1 `CHK("jabber", 1'b0, jabber)
    `CHK("core_rx", rx_act, core_rx)
    @(negedge clk_sys_i) begin
      on     = 1'b0;
      rstn_i = 1'b1;
    end
    repeat (3) @(negedge clk_sys_i);
    $display("reset done");
  endtask : t_reset
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    t_short();
    t_long();
    t_restart();
    t_reset();
    t_long();
    close_out();
  end
endmodule : tb
